//--- shared/fcs_crc_host_map.svh
// Register map, field positions, reset values and timing counts of the CRC verify host
// Notes on behaviour
// - Host sends two unlock writes, then EBh
// - Sub-op 27h selects the CRC check
// - Range count 000Ah/15h, option FFFEh
// - Whole-die count 0004h/09h, option FFFFh, no addresses
// - Expected CRC as four words, offsets 1-4
// - Byte mode: low byte even, high odd
// - Start address at offsets 5-6, zero at 7
// - Stop address at offsets 8-9, zero at 0Ah
// - Confirm 29h, then poll until done
`ifndef FCS_CRC_HOST_MAP_SVH
`define FCS_CRC_HOST_MAP_SVH

`define FCS_REG_CTRL       12'h000
`define FCS_REG_STATUS     12'h004
`define FCS_REG_EXP_LO     12'h008
`define FCS_REG_EXP_HI     12'h00C
`define FCS_REG_START      12'h010
`define FCS_REG_STOP       12'h014

`define FCS_CTRL_GO        0
`define FCS_CTRL_WHOLE     1
`define FCS_CTRL_BYTE      2
`define FCS_ST_BUSY        0
`define FCS_ST_DONE        1
`define FCS_ST_PASS        2
`define FCS_ST_FAIL        3
`define FCS_ST_POLL_LSB    16
`define FCS_RESET_WORD     32'h0000_0000

`define FCS_UNLOCK1_WADDR  27'h000_0555
`define FCS_UNLOCK2_WADDR  27'h000_02AA
`define FCS_UNLOCK1_BADDR  27'h000_0AAA
`define FCS_UNLOCK2_BADDR  27'h000_0555
`define FCS_UNLOCK1_DATA   16'h00AA
`define FCS_UNLOCK2_DATA   16'h0055
`define FCS_EXT_CMD        16'h00EB
`define FCS_SUBOP_CRC      16'h0027
`define FCS_CNT_RANGE_W    16'h000A
`define FCS_CNT_RANGE_B    16'h0015
`define FCS_CNT_WHOLE_W    16'h0004
`define FCS_CNT_WHOLE_B    16'h0009
`define FCS_OPT_RANGE      16'hFFFE
`define FCS_OPT_WHOLE      16'hFFFF
`define FCS_CONFIRM        16'h0029
`define FCS_RSVD_WORD      16'h0000
`define FCS_LAST_WHOLE     5'h0A
`define FCS_LAST_RANGE     5'h10
`define FCS_POLL_TOGGLE    6
`define FCS_POLL_ERR       5

`define FCS_CLK_NS         10
`define FCS_T_SETUP_NS     20
`define FCS_T_PULSE_NS     70
`define FCS_T_HOLD_NS      20
`define FCS_CYC(ns)        (((ns) + `FCS_CLK_NS - 1) / `FCS_CLK_NS)

`endif

//--- shared/fcs_pkg.sv
// Types shared by the CRC verify host and its flash bus cycle engine
package fcs_pkg;
  localparam int FCS_ADDR_W = 26;

  typedef struct packed {
    logic                  ce_n;
    logic                  oe_n;
    logic                  we_n;
    logic                  byte_n;
    logic [FCS_ADDR_W-1:0] addr;
    logic [15:0]           dq_out;
    logic [15:0]           dq_oe;
  } fcs_pins_s;

  typedef struct packed {
    logic                  wr;
    logic                  byte_mode;
    logic [FCS_ADDR_W-1:0] addr;
    logic                  addr_lsb;
    logic [15:0]           data;
  } fcs_req_s;

  typedef struct packed {
    logic [FCS_ADDR_W:0] addr;
    logic [15:0]         data;
    logic                split;
    logic                last;
  } fcs_item_s;

  typedef enum logic [3:0] {
    FCS_E_IDLE  = 4'b0001,
    FCS_E_SETUP = 4'b0010,
    FCS_E_PULSE = 4'b0100,
    FCS_E_HOLD  = 4'b1000
  } fcs_cyc_e;

  typedef enum logic [4:0] {
    FCS_S_IDLE  = 5'b00001,
    FCS_S_ISSUE = 5'b00010,
    FCS_S_WAIT  = 5'b00100,
    FCS_S_POLL  = 5'b01000,
    FCS_S_PWAIT = 5'b10000
  } fcs_seq_e;
endpackage

//--- design/fcs_bus_cycle.sv
// One asynchronous write or read cycle on the flash pins
`timescale 1ns/1ns
`include "fcs_crc_host_map.svh"
module fcs_bus_cycle
  import fcs_pkg::*;
#(
  parameter int SETUP_CYC = `FCS_CYC(`FCS_T_SETUP_NS),
  parameter int PULSE_CYC = `FCS_CYC(`FCS_T_PULSE_NS),
  parameter int HOLD_CYC  = `FCS_CYC(`FCS_T_HOLD_NS)
) (
  input  wire logic      i_core_clk,
  input  wire logic      i_rst,
  input  wire logic      i_go,
  input  wire fcs_req_s  i_req,
  input  wire logic [15:0] i_dq,
  output fcs_pins_s      o_pins,
  output logic           o_done,
  output logic [15:0]    o_rdata
);
  fcs_cyc_e   state;
  fcs_req_s   req;
  logic [7:0] cnt;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state   <= FCS_E_IDLE;
      req     <= '0;
      cnt     <= 8'h00;
      o_done  <= 1'b0;
      o_rdata <= 16'h0000;
      o_pins  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, byte_n: 1'b1, default: '0};
    end else begin
      o_done <= 1'b0;
      unique case (state)
        FCS_E_IDLE: begin
          if (i_go) begin
            req                <= i_req;
            cnt                <= 8'(SETUP_CYC - 1);
            state              <= FCS_E_SETUP;
            o_pins.ce_n        <= 1'b0;
            o_pins.byte_n      <= ~i_req.byte_mode;
            o_pins.addr        <= i_req.addr;
            // Byte mode carries the byte-select address bit on the top data line
            o_pins.dq_out      <= i_req.byte_mode ? {i_req.addr_lsb, 7'h00, i_req.data[7:0]}
                                                  : i_req.data;
            o_pins.dq_oe       <= i_req.byte_mode ? {1'b1, 7'h00, {8{i_req.wr}}}
                                                  : {16{i_req.wr}};
          end
        end
        FCS_E_SETUP: begin
          if (cnt == 8'h00) begin
            cnt         <= 8'(PULSE_CYC - 1);
            state       <= FCS_E_PULSE;
            o_pins.we_n <= ~req.wr;
            o_pins.oe_n <= req.wr;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        FCS_E_PULSE: begin
          if (cnt == 8'h00) begin
            if (!req.wr) begin
              o_rdata <= req.byte_mode ? {8'h00, i_dq[7:0]} : i_dq;
            end
            cnt         <= 8'(HOLD_CYC - 1);
            state       <= FCS_E_HOLD;
            o_pins.we_n <= 1'b1;
            o_pins.oe_n <= 1'b1;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        FCS_E_HOLD: begin
          if (cnt == 8'h00) begin
            state        <= FCS_E_IDLE;
            o_done       <= 1'b1;
            o_pins.ce_n  <= 1'b1;
            o_pins.dq_oe <= 16'h0000;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
      endcase
    end
  end
endmodule

//--- design/fcs_crc_host.sv
// APB-controlled host that issues the CRC verify sequence and polls for its result
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ns
`include "fcs_crc_host_map.svh"
module fcs_crc_host
  import fcs_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic [15:0] i_fl_dq,
  output fcs_pins_s        o_fl_pins
);
  fcs_seq_e    state;
  logic        whole;
  logic        byte_mode;
  logic [63:0] exp_crc;
  logic [31:0] start_addr;
  logic [31:0] stop_addr;
  logic        busy;
  logic        done;
  logic        pass;
  logic        fail;
  logic [15:0] poll_last;
  logic        poll_have;
  logic [4:0]  idx;
  logic        half;
  logic        go;
  fcs_req_s    req;
  logic        cyc_done;
  logic [15:0] cyc_rdata;
  fcs_item_s   item;
  logic        apb_wr;
  logic        start_cmd;

  // Builds the write at position n of the command sequence
  function automatic fcs_item_s seq_item(input logic [4:0] n, input logic wh,
                                         input logic bm, input logic [63:0] crc,
                                         input logic [31:0] sa, input logic [31:0] sp);
    fcs_item_s it;
    it       = '0;
    it.split = 1'b1;
    unique case (n)
      5'h00: begin
        it.addr  = bm ? `FCS_UNLOCK1_BADDR : `FCS_UNLOCK1_WADDR;
        it.data  = `FCS_UNLOCK1_DATA;
        it.split = 1'b0;
      end
      5'h01: begin
        it.addr  = bm ? `FCS_UNLOCK2_BADDR : `FCS_UNLOCK2_WADDR;
        it.data  = `FCS_UNLOCK2_DATA;
        it.split = 1'b0;
      end
      5'h02: begin
        it.data  = `FCS_EXT_CMD;
        it.split = 1'b0;
      end
      5'h03: begin
        it.data  = `FCS_SUBOP_CRC;
        it.split = 1'b0;
      end
      5'h04: begin
        it.split = 1'b0;
        if (wh) begin
          it.data = bm ? `FCS_CNT_WHOLE_B : `FCS_CNT_WHOLE_W;
        end else begin
          it.data = bm ? `FCS_CNT_RANGE_B : `FCS_CNT_RANGE_W;
        end
      end
      5'h05: it.data = wh ? `FCS_OPT_WHOLE : `FCS_OPT_RANGE;
      5'h06, 5'h07, 5'h08, 5'h09: begin
        it.addr = 27'(n - 5'h05);
        it.data = crc[16*(n-5'h06) +: 16];
      end
      5'h0A: begin
        it.addr = 27'h000_0005;
        it.data = sa[15:0];
      end
      5'h0B: begin
        it.addr = 27'h000_0006;
        it.data = sa[31:16];
      end
      5'h0C: begin
        it.addr = 27'h000_0007;
        it.data = `FCS_RSVD_WORD;
      end
      5'h0D: begin
        it.addr = 27'h000_0008;
        it.data = sp[15:0];
      end
      5'h0E: begin
        it.addr = 27'h000_0009;
        it.data = sp[31:16];
      end
      5'h0F: begin
        it.addr = 27'h000_000A;
        it.data = `FCS_RSVD_WORD;
      end
      default: begin
        it.data  = `FCS_CONFIRM;
        it.split = 1'b0;
      end
    endcase
    // Whole-die skips the address words and confirms right after the CRC
    it.last = (n == (wh ? `FCS_LAST_WHOLE : `FCS_LAST_RANGE));
    if (it.last) begin
      it.data  = `FCS_CONFIRM;
      it.addr  = '0;
      it.split = 1'b0;
    end
    return it;
  endfunction

  assign item      = seq_item(idx, whole, byte_mode, exp_crc, start_addr, stop_addr);
  assign apb_wr    = i_psel && i_penable && o_pready && i_pwrite;
  assign start_cmd = apb_wr && (i_paddr == `FCS_REG_CTRL) && i_pwdata[`FCS_CTRL_GO] && !busy;

  // APB slave: no wait states, registers change only at the completing edge
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= `FCS_RESET_WORD;
    end else begin
      o_pready  <= i_psel && !i_penable && !o_pready;
      o_pslverr <= 1'b0;
      o_prdata  <= `FCS_RESET_WORD;
      if (i_psel && !i_penable) begin
        unique case (i_paddr)
          `FCS_REG_CTRL:   o_prdata <= {29'h0, byte_mode, whole, 1'b0};
          `FCS_REG_STATUS: o_prdata <= {poll_last, 12'h000, fail, pass, done, busy};
          `FCS_REG_EXP_LO: o_prdata <= exp_crc[31:0];
          `FCS_REG_EXP_HI: o_prdata <= exp_crc[63:32];
          `FCS_REG_START:  o_prdata <= start_addr;
          `FCS_REG_STOP:   o_prdata <= stop_addr;
          default:         o_pslverr <= 1'b1;
        endcase
        // Parameters are frozen while a command is on the flash bus
        if (i_pwrite && busy && i_paddr != `FCS_REG_STATUS) begin
          o_pslverr <= 1'b1;
        end
      end
    end
  end

  // Software-written parameters
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      whole      <= 1'b0;
      byte_mode  <= 1'b0;
      exp_crc    <= 64'h0000_0000_0000_0000;
      start_addr <= `FCS_RESET_WORD;
      stop_addr  <= `FCS_RESET_WORD;
    end else if (apb_wr && !busy) begin
      unique case (i_paddr)
        `FCS_REG_CTRL: begin
          whole     <= i_pwdata[`FCS_CTRL_WHOLE];
          byte_mode <= i_pwdata[`FCS_CTRL_BYTE];
        end
        `FCS_REG_EXP_LO: exp_crc[31:0]  <= i_pwdata;
        `FCS_REG_EXP_HI: exp_crc[63:32] <= i_pwdata;
        `FCS_REG_START:  start_addr     <= i_pwdata;
        `FCS_REG_STOP:   stop_addr      <= i_pwdata;
        default: ;
      endcase
    end
  end

  // Bytes go low then high; a poll request is taken one edge after go, in PWAIT
  always_comb begin
    req.wr        = !(state == FCS_S_POLL || state == FCS_S_PWAIT);
    req.byte_mode = byte_mode;
    req.data      = half ? {8'h00, item.data[15:8]} : item.data;
    if (!req.wr) begin
      req.addr     = '0;
      req.addr_lsb = 1'b0;
    end else if (byte_mode && item.split) begin
      req.addr     = item.addr[FCS_ADDR_W-1:0];
      req.addr_lsb = half;
    end else if (byte_mode) begin
      req.addr     = item.addr[FCS_ADDR_W:1];
      req.addr_lsb = item.addr[0];
    end else begin
      req.addr     = item.addr[FCS_ADDR_W-1:0];
      req.addr_lsb = 1'b0;
    end
  end

  // Sequencer: writes the whole command, then polls until the device settles
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state     <= FCS_S_IDLE;
      idx       <= 5'h00;
      half      <= 1'b0;
      go        <= 1'b0;
      busy      <= 1'b0;
      done      <= 1'b0;
      pass      <= 1'b0;
      fail      <= 1'b0;
      poll_last <= 16'h0000;
      poll_have <= 1'b0;
    end else begin
      go <= 1'b0;
      unique case (state)
        FCS_S_IDLE: begin
          if (start_cmd) begin
            state     <= FCS_S_ISSUE;
            idx       <= 5'h00;
            half      <= 1'b0;
            busy      <= 1'b1;
            done      <= 1'b0;
            pass      <= 1'b0;
            fail      <= 1'b0;
            poll_have <= 1'b0;
          end
        end
        FCS_S_ISSUE: begin
          go    <= 1'b1;
          state <= FCS_S_WAIT;
        end
        FCS_S_WAIT: begin
          if (cyc_done) begin
            if (byte_mode && item.split && !half) begin
              half  <= 1'b1;
              state <= FCS_S_ISSUE;
            end else if (item.last) begin
              half  <= 1'b0;
              state <= FCS_S_POLL;
            end else begin
              half  <= 1'b0;
              idx   <= idx + 5'h01;
              state <= FCS_S_ISSUE;
            end
          end
        end
        FCS_S_POLL: begin
          go    <= 1'b1;
          state <= FCS_S_PWAIT;
        end
        FCS_S_PWAIT: begin
          if (cyc_done) begin
            poll_last <= cyc_rdata;
            poll_have <= 1'b1;
            state     <= FCS_S_POLL;
            if (poll_have && (cyc_rdata[`FCS_POLL_TOGGLE] == poll_last[`FCS_POLL_TOGGLE]
                || (cyc_rdata[`FCS_POLL_ERR] && poll_last[`FCS_POLL_ERR]))) begin
              state <= FCS_S_IDLE;
              busy  <= 1'b0;
              done  <= 1'b1;
              fail  <= cyc_rdata[`FCS_POLL_ERR];
              pass  <= ~cyc_rdata[`FCS_POLL_ERR];
            end
          end
        end
      endcase
    end
  end

  fcs_bus_cycle u_cycle (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_go       (go),
    .i_req      (req),
    .i_dq       (i_fl_dq),
    .o_pins     (o_fl_pins),
    .o_done     (cyc_done),
    .o_rdata    (cyc_rdata)
  );
endmodule

//--- sim/fcs_crc_host_props.sv
// Checker of the CRC verify host's register bus and flash pin timing
`timescale 1ns/1ns
module fcs_crc_host_props
  import fcs_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [15:0] i_fl_dq,
  input wire fcs_pins_s   o_fl_pins
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  property p_ready_answer;
    i_psel && !i_penable |=> o_pready;
  endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("pready late");
  property p_ready_pulse;
    o_pready |=> !o_pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  property p_unmapped;
    i_psel && !i_penable && i_paddr > 12'h014 |=> o_pslverr && o_prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_strobe_in_ce;
    !o_fl_pins.we_n || !o_fl_pins.oe_n |-> !o_fl_pins.ce_n && (o_fl_pins.we_n || o_fl_pins.oe_n);
  endproperty
  a_strobe_in_ce: assert property (p_strobe_in_ce) else $error("strobe outside cycle");
  property p_we_width;
    $fell(o_fl_pins.we_n) |-> (!o_fl_pins.we_n) [*7] ##1 o_fl_pins.we_n;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write pulse width wrong");
  property p_we_setup;
    $fell(o_fl_pins.we_n) |-> $past(o_fl_pins.ce_n, 2) == 1'b0 && $past(o_fl_pins.ce_n, 3);
  endproperty
  a_we_setup: assert property (p_we_setup) else $error("write setup wrong");
  property p_pins_stable;
    !o_fl_pins.ce_n && $past(o_fl_pins.ce_n) == 1'b0 |-> $stable(o_fl_pins.addr)
      && $stable(o_fl_pins.dq_out) && $stable(o_fl_pins.dq_oe) && $stable(o_fl_pins.byte_n);
  endproperty
  a_pins_stable: assert property (p_pins_stable) else $error("pins moved in cycle");
  property p_ce_gap;
    $rose(o_fl_pins.ce_n) |-> o_fl_pins.ce_n [*2];
  endproperty
  a_ce_gap: assert property (p_ce_gap) else $error("cycle gap short");
  property p_byte_sel;
    !o_fl_pins.ce_n && !o_fl_pins.byte_n |-> o_fl_pins.dq_oe[15];
  endproperty
  a_byte_sel: assert property (p_byte_sel) else $error("byte select not driven");
endmodule

bind fcs_crc_host fcs_crc_host_props i_props (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_fl_dq(i_fl_dq), .o_fl_pins(o_fl_pins));

//--- sim/fcs_flash_model.sv
// Behavioural flash device that decodes the CRC verify command and answers status reads
`timescale 1ns/1ns
module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter logic [63:0] ARRAY_CRC = 64'h5A5A_0F0F_C3C3_1234
) (
  input  wire fcs_pins_s i_pins,
  output logic [15:0]    o_dq
);
  logic [42:0] log_q[$];
  logic [15:0] pw[1:10];
  logic [26:0] ba;
  logic [15:0] wd;
  logic        tgl = 1'b0;
  logic        err = 1'b0;
  logic        ran = 1'b0;
  logic        whole;
  int          busy_reads = 3;
  int          busy_left = 0;
  wire  [15:0] stat = {9'h000, tgl, err && busy_left == 0, 5'h00};
  localparam logic [63:0] POLY = 64'h42F0_E1EB_A9EA_3693;

  // Array byte at address a holds a[7:0] ^ A5h; the stop byte is included
  function automatic logic [63:0] crc_of(input logic [31:0] a0, input logic [31:0] a1);
    logic [63:0] c;
    logic [31:0] a;
    logic [7:0]  b;
    logic        fb;
    c = 64'h0000_0000_0000_0000;
    for (a = a0; a <= a1; a++) begin
      b = a[7:0] ^ 8'hA5;
      for (int i = 0; i < 8; i++) begin
        fb = c[63] ^ b[i];
        c = c << 1;
        if (fb) c = c ^ POLY;
      end
    end
    return c;
  endfunction

  // A released bus shows the inverse, so a stale read cannot pass
  assign o_dq = (!i_pins.ce_n && !i_pins.oe_n) ? stat : ~stat;

  always @(posedge i_pins.we_n) begin
    if (!i_pins.ce_n) begin
      ba = i_pins.byte_n ? {1'b0, i_pins.addr} : {i_pins.addr, i_pins.dq_out[15]};
      wd = i_pins.byte_n ? i_pins.dq_out : {8'h00, i_pins.dq_out[7:0]};
      log_q.push_back({ba, wd});
      for (int k = 1; k <= 10; k++) begin
        if (!i_pins.byte_n && ba == 2 * k) pw[k][7:0] = wd[7:0];
        if (!i_pins.byte_n && ba == 2 * k + 1) pw[k][15:8] = wd[7:0];
        if (i_pins.byte_n && ba == k) pw[k] = wd;
      end
      if (ba == 27'h000_0000 && wd == 16'h0029) begin
        whole = log_q.size() > 4 && log_q[4][15:0] inside {16'h0004, 16'h0009};
        ran = whole || {pw[9], pw[8]} > {pw[6], pw[5]};
        err = ran && {pw[4], pw[3], pw[2], pw[1]} !=
              (whole ? ARRAY_CRC : crc_of({pw[6], pw[5]}, {pw[9], pw[8]}));
        busy_left = ran ? busy_reads : 0;
      end
    end
  end

  // Each status read toggles bit 6 until the work is done
  always @(posedge i_pins.oe_n) begin
    if (!i_pins.ce_n && busy_left > 0) begin
      tgl = ~tgl;
      busy_left--;
    end
  end
endmodule

//--- sim/fcs_crc_host_tb.sv
// Self-checking bench of the CRC verify host against a behavioural flash device
`timescale 1ns/1ns
module fcs_crc_host_tb
  import fcs_pkg::*;
;
  localparam logic [63:0] DEV_CRC = 64'h5A5A_0F0F_C3C3_1234;
  localparam logic [63:0] CRC_POLY = 64'h42F0_E1EB_A9EA_3693;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rdata;
  logic        rerr;
  logic [15:0] dev_dq;
  logic [15:0] fl_dq;
  fcs_pins_s   pins;
  int          n_errors = 0;
  int          checks_done = 0;

  always #5 clk = ~clk;
  assign fl_dq = (pins.dq_oe & pins.dq_out) | (~pins.dq_oe & dev_dq);

  fcs_crc_host i_dut (.i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_fl_dq(fl_dq), .o_fl_pins(pins));
  fcs_flash_model #(.ARRAY_CRC(DEV_CRC)) i_flash (.i_pins(pins), .o_dq(dev_dq));

  task automatic close_out;
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // The device model's array byte at address a is a[7:0] ^ A5h, fed LSB first
  function automatic logic [63:0] range_crc(input logic [31:0] sa, input logic [31:0] sp);
    logic [63:0] c;
    logic [31:0] a;
    logic [7:0]  b;
    c = 64'h0000_0000_0000_0000;
    for (a = sa; a <= sp; a++) begin
      b = a[7:0] ^ 8'hA5;
      for (int i = 0; i < 8; i++) c = {c[62:0], 1'b0} ^ ({64{c[63] ^ b[i]}} & CRC_POLY);
    end
    return c;
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic void pw(input logic bm, input logic [26:0] a, input logic [15:0] d,
                             ref logic [42:0] q[$]);
    if (bm) begin
      q.push_back({a << 1, 8'h00, d[7:0]});
      q.push_back({(a << 1) | 27'h000_0001, 8'h00, d[15:8]});
    end else begin
      q.push_back({a, d});
    end
  endfunction

  function automatic void exp_seq(input logic bm, input logic whole, input logic [63:0] c,
                                  input logic [31:0] sa, input logic [31:0] sp,
                                  ref logic [42:0] q[$]);
    logic [15:0] r[6];
    r = '{sa[15:0], sa[31:16], 16'h0000, sp[15:0], sp[31:16], 16'h0000};
    q.push_back(bm ? {27'h000_0AAA, 16'h00AA} : {27'h000_0555, 16'h00AA});
    q.push_back(bm ? {27'h000_0555, 16'h0055} : {27'h000_02AA, 16'h0055});
    q.push_back({27'h000_0000, 16'h00EB});
    q.push_back({27'h000_0000, 16'h0027});
    q.push_back({27'h000_0000, whole ? (bm ? 16'h0009 : 16'h0004) : (bm ? 16'h0015 : 16'h000A)});
    pw(bm, 27'h000_0000, whole ? 16'hFFFF : 16'hFFFE, q);
    for (int k = 1; k <= 4; k++) pw(bm, 27'(k), c[16*k-16 +: 16], q);
    for (int k = 0; k < 6 && !whole; k++) pw(bm, 27'(k + 5), r[k], q);
    q.push_back({27'h000_0000, 16'h0029});
  endfunction

  task automatic run(input logic bm, input logic whole, input logic good, input logic bad);
    logic [63:0] crc;
    logic [31:0] sa;
    logic [31:0] sp;
    logic [42:0] q[$];
    int n = 0;
    sa = ($urandom >> 2) + 32'h0000_0001;
    sp = bad ? sa - 32'($urandom_range(0, 1)) : sa + 32'($urandom_range(1, 255));
    crc = !good ? {$urandom, $urandom} : whole ? DEV_CRC : range_crc(sa, sp);
    i_flash.busy_reads = $urandom_range(0, 6);
    i_flash.log_q.delete();
    exp_seq(bm, whole, crc, sa, sp, q);
    apb(1'b1, 12'h008, crc[31:0]);
    chk("write_err", 1'b0, rerr);
    apb(1'b1, 12'h00C, crc[63:32]);
    apb(1'b1, 12'h010, sa);
    apb(1'b1, 12'h014, sp);
    apb(1'b1, 12'h000, {29'h0000_0000, bm, whole, 1'b1});
    apb(1'b1, 12'h008, 32'h0000_0000);
    chk("busy_write_err", 1'b1, rerr);
    do apb(1'b0, 12'h004, 32'h0000_0000); while (rdata[1] !== 1'b1 && ++n < 1000);
    chk("busy_done", 2'b10, rdata[1:0]);
    chk("fail", !good && !bad, rdata[3]);
    chk("pass", good || bad, rdata[2]);
    chk("polled_err", !good && !bad, rdata[21]);
    chk("device_ran", !bad, i_flash.ran);
    chk("n_writes", q.size(), i_flash.log_q.size());
    foreach (q[i]) chk("write", q[i], i_flash.log_q[i]);
  endtask

  initial begin
    void'($urandom(67));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("status_reset", 32'h0000_0000, rdata);
    chk("pins_idle", 3'b111, {pins.ce_n, pins.we_n, pins.oe_n});
    apb(1'b0, 12'h040, 32'h0000_0000);
    chk("unmapped_err", 1'b1, rerr);
    chk("unmapped_data", 32'h0000_0000, rdata);
    for (int t = 0; t < 10; t++) run(t[0], t[1] && t < 8, t[2] && t < 8, t >= 8);
    close_out();
  end

  // Ten runs need some 4k cycles; the watchdog allows twenty times that
  initial begin
    #800_000;
    n_errors++;
    close_out();
  end
endmodule
